// ===== design/rss_rx_stats.sv
// rss_rx_stats: rx status and statistics increment generator
// Operation
// [R1] Flag every received signal ordered-set word on a status output.
// [R2] Test enable set to 1 checks incoming blocks against scrambled idle.
// [R3] Mismatches per cycle appear on a 3-bit one-cycle pulse.
// [R4] Mismatch output stays zero while test enable is clear.
// [R5] Lane 0 marker parity byte is presented on its own output.
// [R6] A strobe marks exactly when the marker parity byte is valid.
// [R7] Bytes received per cycle appear on an 8-bit increment.
// [R8] Packets received per cycle appear on a 4-bit increment.
// [R9] Good-byte increment carries a packet's length only if error-free.
// [R10] Good-packet increment pulses only on error-free packet completion.
// [R11] Bad-FCS pulse for packets from 64 bytes to maximum length.
// [R12] Exactly one size bin pulses for each packet in 64 to 9215.
// [R13] Packets under 64 bytes counted on a 4-bit increment.
// [R14] Giant increment pulses for packets above 9215 bytes.
// [R15] Good packets classified unicast, multicast or broadcast.
// [R16] Over-maximum with good FCS pulses its own increment.
// [R17] Over-maximum pulses regardless of FCS.
// [R18] Over-maximum with bad FCS pulses its own increment.
// [R19] Under-minimum splits into good-FCS and bad-FCS 4-bit increments.
// [R20] Good VLAN-tagged packets pulse the tagged increment.
// [R21] Length-field error with good FCS pulses its increment.
// [R22] Good-FCS pause and priority pause frames pulse separate increments.
// [R23] The user sums all increments every cycle; no totals are kept here.
`timescale 1ns/1ps

module rss_rx_stats
  import rss_pkg::*;
#(
  parameter int BLOCKS = 4
)
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  // axi4-lite slave
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [AXI_DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [AXI_DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // decoded receive pcs events
  input wire logic rx_sig_os_word_i,
  input wire logic [BLOCKS-1:0] rx_blk_valid_i,
  input wire logic [BLOCKS-1:0] rx_blk_is_idle_i,
  input wire logic rx_marker_valid_i,
  input wire logic [7:0] rx_marker_parity_i,
  // receive mac packet events
  input wire logic [7:0] rx_cycle_bytes_i,
  input wire logic rx_eop_valid_i,
  input wire logic [LEN_W-1:0] rx_eop_len_i,
  input wire logic rx_eop_fcs_bad_i,
  input wire logic rx_eop_frame_err_i,
  input wire logic [1:0] rx_eop_dest_i,
  input wire logic rx_eop_vlan_i,
  input wire logic rx_eop_len_field_err_i,
  input wire logic rx_eop_pause_i,
  input wire logic rx_eop_prio_pause_i,
  // status and increments
  output logic rx_signal_ordered_set_seen_o,
  output logic [2:0] rx_test_mismatch_incr_o,
  output logic [7:0] rx_first_lane_marker_parity_o,
  output logic rx_first_lane_marker_parity_strobe_o,
  output logic [7:0] rx_total_bytes_incr_o,
  output logic [3:0] rx_total_packets_incr_o,
  output logic [13:0] rx_good_bytes_incr_o,
  output logic rx_good_packets_incr_o,
  output logic rx_crc_error_incr_o,
  output logic [SIZE_BINS-1:0] rx_size_bin_incr_o,
  output logic [3:0] rx_small_incr_o,
  output logic rx_giant_incr_o,
  output logic rx_unicast_incr_o,
  output logic rx_multicast_incr_o,
  output logic rx_broadcast_incr_o,
  output logic rx_over_max_good_incr_o,
  output logic rx_over_max_any_incr_o,
  output logic rx_over_max_bad_incr_o,
  output logic [3:0] rx_under_min_good_incr_o,
  output logic [3:0] rx_under_min_bad_incr_o,
  output logic rx_tagged_frame_incr_o,
  output logic rx_length_field_error_incr_o,
  output logic rx_pause_incr_o,
  output logic rx_prio_pause_incr_o
);

  // merge a write into a register honouring byte strobes
  function automatic logic [31:0] apply_strb(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_val[i*8 +: 8];
    end
    return res;
  endfunction : apply_strb

  // one-hot histogram bin, zero outside 64..9215
  function automatic logic [SIZE_BINS-1:0] size_bin(input logic [13:0] len);
    logic [SIZE_BINS-1:0] b;
    b = '0;
    b[0] = (len == LEN_64);
    b[1] = (len > LEN_64) && (len <= LEN_127);
    b[2] = (len > LEN_127) && (len <= LEN_255);
    b[3] = (len > LEN_255) && (len <= LEN_511);
    b[4] = (len > LEN_511) && (len <= LEN_1023);
    b[5] = (len > LEN_1023) && (len <= LEN_1518);
    b[6] = (len > LEN_1518) && (len <= LEN_1522);
    b[7] = (len > LEN_1522) && (len <= LEN_1548);
    b[8] = (len > LEN_1548) && (len <= LEN_2047);
    b[9] = (len > LEN_2047) && (len <= LEN_4095);
    b[10] = (len > LEN_4095) && (len <= LEN_8191);
    b[11] = (len > LEN_8191) && (len <= LEN_9215);
    return b;
  endfunction : size_bin

  // control registers
  logic tp_en_q;
  logic [13:0] max_len_q;
  logic [13:0] min_len_q;
  logic [31:0] ctrl_wr_word;
  logic [31:0] max_wr_word;
  logic [31:0] min_wr_word;

  // axi handshake state
  logic awready_q;
  logic wready_q;
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] wr_addr_q;
  logic [31:0] wr_data_q;
  logic [3:0] wr_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic do_write;

  // both halves of a write are in and no response is pending
  assign do_write = aw_full_q && w_full_q && !bvalid_q;

  // write address and data accepted independently, in either order
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 32'h0000_0000;
      wr_strb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid_i && awready_q)
      begin
        awready_q <= 1'b0;
        aw_full_q <= 1'b1;
        wr_addr_q <= s_axi_awaddr_i;
      end
      else if (!aw_full_q && !bvalid_q)
        awready_q <= 1'b1;
      if (s_axi_wvalid_i && wready_q)
      begin
        wready_q <= 1'b0;
        w_full_q <= 1'b1;
        wr_data_q <= s_axi_wdata_i;
        wr_strb_q <= s_axi_wstrb_i;
      end
      else if (!w_full_q && !bvalid_q)
        wready_q <= 1'b1;
      if (do_write)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
      end
    end
  end

  // write response follows the cycle after both halves are held
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      unique case (wr_addr_q)
        CTRL_OFFS, MAX_LEN_OFFS, MIN_LEN_OFFS, STATUS_OFFS:
          bresp_q <= RESP_OKAY;
        default:
          bresp_q <= RESP_DECERR;
      endcase
    end
    else if (bvalid_q && s_axi_bready_i)
      bvalid_q <= 1'b0;
  end

  // strobe-merged words; a select on a call result is not portable
  assign ctrl_wr_word = apply_strb({31'h0, tp_en_q}, wr_data_q, wr_strb_q);
  assign max_wr_word = apply_strb({18'h0, max_len_q}, wr_data_q, wr_strb_q);
  assign min_wr_word = apply_strb({18'h0, min_len_q}, wr_data_q, wr_strb_q);

  // [R2] test enable register
  // status is read-only; writes to it are accepted and dropped
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      tp_en_q <= CTRL_TP_EN_RST;
      max_len_q <= MAX_LEN_RST;
      min_len_q <= MIN_LEN_RST;
    end
    else if (do_write)
    begin
      if (wr_addr_q == CTRL_OFFS)
        tp_en_q <= ctrl_wr_word[CTRL_TP_EN_BIT];
      if (wr_addr_q == MAX_LEN_OFFS)
        max_len_q <= max_wr_word[LEN_W-1:0];
      if (wr_addr_q == MIN_LEN_OFFS)
        min_len_q <= min_wr_word[LEN_W-1:0];
    end
  end

  // read channel: data one cycle after the address is taken
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid_i && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      unique case (s_axi_araddr_i)
        CTRL_OFFS:
          rdata_q[CTRL_TP_EN_BIT] <= tp_en_q;
        MAX_LEN_OFFS:
          rdata_q[LEN_W-1:0] <= max_len_q;
        MIN_LEN_OFFS:
          rdata_q[LEN_W-1:0] <= min_len_q;
        STATUS_OFFS:
        begin
          rdata_q[STATUS_PARITY_LSB +: 8] <= rx_first_lane_marker_parity_o;
          rdata_q[STATUS_TP_ACTIVE_BIT] <= tp_en_q;
          rdata_q[STATUS_SIG_OS_BIT] <= rx_signal_ordered_set_seen_o;
        end
        default:
          rresp_q <= RESP_DECERR;
      endcase
    end
    else if (rvalid_q && s_axi_rready_i)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
    else if (!rvalid_q)
      arready_q <= 1'b1;
  end

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;

  // packet classification terms
  logic fcs_ok;
  logic over_max;
  logic under_min;
  logic pkt_good;
  logic [2:0] mismatch_cnt;

  assign fcs_ok = !rx_eop_fcs_bad_i;
  assign over_max = rx_eop_len_i > max_len_q;
  assign under_min = rx_eop_len_i < min_len_q;
  assign pkt_good = rx_eop_valid_i && fcs_ok && !rx_eop_frame_err_i &&
                    !over_max && !under_min;

  // [R2] count valid blocks that are not scrambled idle
  always_comb
  begin
    mismatch_cnt = 3'h0;
    for (int i = 0; i < BLOCKS; i++)
      mismatch_cnt = mismatch_cnt +
                     3'(rx_blk_valid_i[i] && !rx_blk_is_idle_i[i]);
  end

  // pcs side status, all one-cycle pulses
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      rx_signal_ordered_set_seen_o <= 1'b0;
      rx_test_mismatch_incr_o <= 3'h0;
      rx_first_lane_marker_parity_strobe_o <= 1'b0;
    end
    else
    begin
      // [R1] ordered-set flag
      rx_signal_ordered_set_seen_o <= rx_sig_os_word_i;
      // [R3] [R4] gated mismatch count
      rx_test_mismatch_incr_o <= tp_en_q ? mismatch_cnt : 3'h0;
      // [R6] parity valid strobe
      rx_first_lane_marker_parity_strobe_o <= rx_marker_valid_i;
    end
  end

  // [R5] parity byte held between markers so it can be read later
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
      rx_first_lane_marker_parity_o <= 8'h00;
    else if (rx_marker_valid_i)
      rx_first_lane_marker_parity_o <= rx_marker_parity_i;
  end

  // volume increments; totals are left to the user's counters
  // [R23] no accumulation here
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      rx_total_bytes_incr_o <= 8'h00;
      rx_total_packets_incr_o <= 4'h0;
      rx_good_bytes_incr_o <= 14'h0000;
      rx_good_packets_incr_o <= 1'b0;
    end
    else
    begin
      // [R7] bytes this cycle
      rx_total_bytes_incr_o <= rx_cycle_bytes_i;
      // [R8] packets this cycle
      rx_total_packets_incr_o <= {3'h0, rx_eop_valid_i};
      // [R9] good bytes on completion
      rx_good_bytes_incr_o <= pkt_good ? rx_eop_len_i : 14'h0000;
      // [R10] good packet pulse
      rx_good_packets_incr_o <= pkt_good;
    end
  end

  // size and error classes, one pulse per completed packet
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      rx_crc_error_incr_o <= 1'b0;
      rx_size_bin_incr_o <= '0;
      rx_small_incr_o <= 4'h0;
      rx_giant_incr_o <= 1'b0;
      rx_over_max_good_incr_o <= 1'b0;
      rx_over_max_any_incr_o <= 1'b0;
      rx_over_max_bad_incr_o <= 1'b0;
      rx_under_min_good_incr_o <= 4'h0;
      rx_under_min_bad_incr_o <= 4'h0;
      rx_length_field_error_incr_o <= 1'b0;
    end
    else
    begin
      // [R11] bad fcs in legal range
      rx_crc_error_incr_o <= rx_eop_valid_i && rx_eop_fcs_bad_i &&
                             (rx_eop_len_i >= LEN_64) && !over_max;
      // [R12] histogram bin
      rx_size_bin_incr_o <= rx_eop_valid_i ? size_bin(rx_eop_len_i) : '0;
      // [R13] runt count
      rx_small_incr_o <= {3'h0, rx_eop_valid_i && (rx_eop_len_i < LEN_64)};
      // [R14] giant packet
      rx_giant_incr_o <= rx_eop_valid_i && (rx_eop_len_i > LEN_9215);
      // [R16] over max, good fcs
      rx_over_max_good_incr_o <= rx_eop_valid_i && over_max && fcs_ok;
      // [R17] over max, any fcs
      rx_over_max_any_incr_o <= rx_eop_valid_i && over_max;
      // [R18] over max, bad fcs
      rx_over_max_bad_incr_o <= rx_eop_valid_i && over_max && !fcs_ok;
      // [R19] under min split by fcs
      rx_under_min_good_incr_o <= {3'h0,
                                   rx_eop_valid_i && under_min && fcs_ok};
      rx_under_min_bad_incr_o <= {3'h0,
                                  rx_eop_valid_i && under_min && !fcs_ok};
      // [R21] length field error
      rx_length_field_error_incr_o <= rx_eop_valid_i && fcs_ok &&
                                      rx_eop_len_field_err_i;
    end
  end

  // frame-type increments for good or good-fcs packets
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      rx_unicast_incr_o <= 1'b0;
      rx_multicast_incr_o <= 1'b0;
      rx_broadcast_incr_o <= 1'b0;
      rx_tagged_frame_incr_o <= 1'b0;
      rx_pause_incr_o <= 1'b0;
      rx_prio_pause_incr_o <= 1'b0;
    end
    else
    begin
      // [R15] destination class
      rx_unicast_incr_o <= pkt_good && (rx_eop_dest_i == DEST_UNICAST);
      rx_multicast_incr_o <= pkt_good && (rx_eop_dest_i == DEST_MULTICAST);
      rx_broadcast_incr_o <= pkt_good && (rx_eop_dest_i == DEST_BROADCAST);
      // [R20] tagged frame
      rx_tagged_frame_incr_o <= pkt_good && rx_eop_vlan_i;
      // [R22] pause frames
      rx_pause_incr_o <= rx_eop_valid_i && fcs_ok && rx_eop_pause_i;
      rx_prio_pause_incr_o <= rx_eop_valid_i && fcs_ok && rx_eop_prio_pause_i;
    end
  end

  // checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_marker_in;
    rx_marker_valid_i ##0 $stable(reset_i);
  endsequence

  sequence s_good_done;
    pkt_good;
  endsequence

  a_sig_os_flag: assert property ( // [R1]
    rx_sig_os_word_i |=> rx_signal_ordered_set_seen_o)
    else $error("ordered-set word not flagged");

  a_mismatch_count: assert property ( // [R3]
    tp_en_q |=> rx_test_mismatch_incr_o == $past(mismatch_cnt))
    else $error("mismatch count wrong");

  a_mismatch_idle: assert property ( // [R4]
    !tp_en_q |=> rx_test_mismatch_incr_o == 3'h0)
    else $error("mismatch nonzero with test off");

  a_parity_strobe: assert property ( // [R5]
    s_marker_in |=> rx_first_lane_marker_parity_strobe_o &&
      rx_first_lane_marker_parity_o == $past(rx_marker_parity_i))
    else $error("marker parity not presented");

  a_strobe_cause: assert property ( // [R6]
    rx_first_lane_marker_parity_strobe_o |-> $past(rx_marker_valid_i))
    else $error("parity strobe without marker");

  a_good_bytes: assert property ( // [R9]
    s_good_done |=> rx_good_bytes_incr_o == $past(rx_eop_len_i) &&
      rx_good_packets_incr_o)
    else $error("good byte increment wrong");

  a_bin_onehot: assert property ( // [R12]
    rx_eop_valid_i && rx_eop_len_i >= LEN_64 && rx_eop_len_i <= LEN_9215
      |=> $onehot(rx_size_bin_incr_o))
    else $error("size bin not exactly one");

  a_over_split: assert property ( // [R17]
    rx_over_max_any_incr_o |->
      (rx_over_max_good_incr_o ^ rx_over_max_bad_incr_o))
    else $error("over-max classes inconsistent");

  a_crc_range: assert property ( // [R11]
    rx_crc_error_incr_o |-> $past(rx_eop_len_i) >= LEN_64 &&
      $past(rx_eop_fcs_bad_i))
    else $error("crc error outside range");

  a_write_resp: assert property (
    do_write |=> s_axi_bvalid_o)
    else $error("write response missing");

endmodule : rss_rx_stats

// ===== pkg/rss_pkg.sv
// rss_pkg: register map, length thresholds and codes for rx statistics
package rss_pkg;

  // bus geometry
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] CTRL_OFFS = 8'h00;
  localparam logic [7:0] MAX_LEN_OFFS = 8'h04;
  localparam logic [7:0] MIN_LEN_OFFS = 8'h08;
  localparam logic [7:0] STATUS_OFFS = 8'h0c;

  // field positions
  localparam int CTRL_TP_EN_BIT = 0;
  localparam int LEN_W = 14;
  localparam int STATUS_PARITY_LSB = 0;
  localparam int STATUS_TP_ACTIVE_BIT = 8;
  localparam int STATUS_SIG_OS_BIT = 9;

  // reset values
  localparam logic CTRL_TP_EN_RST = 1'b0;
  localparam logic [13:0] MAX_LEN_RST = 14'h05ee;
  localparam logic [13:0] MIN_LEN_RST = 14'h0040;

  // histogram and size-class boundaries, in bytes
  localparam logic [13:0] LEN_64 = 14'h0040;
  localparam logic [13:0] LEN_127 = 14'h007f;
  localparam logic [13:0] LEN_255 = 14'h00ff;
  localparam logic [13:0] LEN_511 = 14'h01ff;
  localparam logic [13:0] LEN_1023 = 14'h03ff;
  localparam logic [13:0] LEN_1518 = 14'h05ee;
  localparam logic [13:0] LEN_1522 = 14'h05f2;
  localparam logic [13:0] LEN_1548 = 14'h060c;
  localparam logic [13:0] LEN_2047 = 14'h07ff;
  localparam logic [13:0] LEN_4095 = 14'h0fff;
  localparam logic [13:0] LEN_8191 = 14'h1fff;
  localparam logic [13:0] LEN_9215 = 14'h23ff;
  localparam int SIZE_BINS = 12;

  // destination address classes
  localparam logic [1:0] DEST_UNICAST = 2'h0;
  localparam logic [1:0] DEST_MULTICAST = 2'h1;
  localparam logic [1:0] DEST_BROADCAST = 2'h2;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : rss_pkg

// ===== testbench/rss_stat_acc.sv
// rss_stat_acc: user-side wide counters fed by the rx increments
`timescale 1ns/1ps

module rss_stat_acc
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [3:0] pkt_incr_i,
  input wire logic [7:0] byte_incr_i,
  input wire logic [13:0] good_incr_i,
  output logic [31:0] pkt_total_o,
  output logic [31:0] byte_total_o,
  output logic [31:0] good_total_o
);
  // sum every cycle
  // increments live one cycle only, so a skipped edge loses counts
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      pkt_total_o <= '0;
      byte_total_o <= '0;
      good_total_o <= '0;
    end
    else
    begin
      pkt_total_o <= pkt_total_o + 32'(pkt_incr_i);
      byte_total_o <= byte_total_o + 32'(byte_incr_i);
      good_total_o <= good_total_o + 32'(good_incr_i);
    end
  end
endmodule : rss_stat_acc

// ===== testbench/tb.sv
// tb: self-checking bench for the rx statistics increment block
`timescale 1ns/1ps

module tb;
  import rss_pkg::*;
  localparam int LO[12] = '{64, 65, 128, 256, 512, 1024, 1519, 1523, 1549,
    2048, 4096, 8192};
  logic clk = 0, rst = 1;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, sp = '0, sb = '0, sg = '0;
  logic [31:0] ap, ab, ag;
  logic [3:0] wstrb = '0, bv = '0, bi = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, dst = '0;
  logic sig = 0, mkv = 0, pv = 0, fb = 0, fe = 0, vl = 0, lf = 0, pz = 0;
  logic pp = 0, tp = 0;
  logic [7:0] mkp = '0, cb = '0, lp = '0;
  logic [13:0] len = '0, mx = MAX_LEN_RST, mn = MIN_LEN_RST;
  logic [13:0] cl[] = '{0, 51, 52, 63, 64, 65, 127, 128, 255, 256, 511, 512,
    1023, 1024, 1518, 1519, 1522, 1523, 1548, 1549, 2000, 2001, 2047, 2048,
    4095, 4096, 8191, 8192, 9215, 9216, 16383};
  logic [75:0] e = '0;
  wire [75:0] got;
  int n_mismatch = 0, tests_run = 0;

  always #2 clk = ~clk;

  rss_rx_stats #(.BLOCKS(4)) dut_u (
    .core_clk_i(clk), .reset_i(rst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .rx_sig_os_word_i(sig), .rx_blk_valid_i(bv), .rx_blk_is_idle_i(bi),
    .rx_marker_valid_i(mkv), .rx_marker_parity_i(mkp),
    .rx_cycle_bytes_i(cb), .rx_eop_valid_i(pv), .rx_eop_len_i(len),
    .rx_eop_fcs_bad_i(fb), .rx_eop_frame_err_i(fe), .rx_eop_dest_i(dst),
    .rx_eop_vlan_i(vl), .rx_eop_len_field_err_i(lf), .rx_eop_pause_i(pz),
    .rx_eop_prio_pause_i(pp),
    .rx_signal_ordered_set_seen_o(got[75]),
    .rx_test_mismatch_incr_o(got[74:72]),
    .rx_first_lane_marker_parity_o(got[71:64]),
    .rx_first_lane_marker_parity_strobe_o(got[63]),
    .rx_total_bytes_incr_o(got[62:55]), .rx_total_packets_incr_o(got[54:51]),
    .rx_good_packets_incr_o(got[50]), .rx_good_bytes_incr_o(got[49:36]),
    .rx_crc_error_incr_o(got[35]), .rx_size_bin_incr_o(got[34:23]),
    .rx_small_incr_o(got[22:19]), .rx_giant_incr_o(got[18]),
    .rx_unicast_incr_o(got[17]), .rx_multicast_incr_o(got[16]),
    .rx_broadcast_incr_o(got[15]), .rx_over_max_good_incr_o(got[14]),
    .rx_over_max_any_incr_o(got[13]), .rx_over_max_bad_incr_o(got[12]),
    .rx_under_min_good_incr_o(got[11:8]), .rx_under_min_bad_incr_o(got[7:4]),
    .rx_tagged_frame_incr_o(got[3]), .rx_length_field_error_incr_o(got[2]),
    .rx_pause_incr_o(got[1]), .rx_prio_pause_incr_o(got[0])
  );

  rss_stat_acc acc_u (
    .core_clk_i(clk), .reset_i(rst), .pkt_incr_i(got[54:51]),
    .byte_incr_i(got[62:55]), .good_incr_i(got[49:36]),
    .pkt_total_o(ap), .byte_total_o(ab), .good_total_o(ag)
  );

  // expected outputs for the inputs now applied, same layout as got
  function logic [75:0] ex();
    logic g, o;
    logic [11:0] b;
    g = pv & !fb & !fe & len >= mn & len <= mx;
    o = pv & len > mx;
    b = '0;
    for (int k = 11; k >= 0; k--)
      if (b == '0 && len >= LO[k] && len <= LEN_9215) b[k] = pv;
    return {sig, tp ? 3'($countones(bv & ~bi)) : 3'h0, lp, mkv, cb,
      {3'h0, pv}, g, g ? len : 14'h0, pv & fb & len >= LEN_64 & len <= mx,
      b, {3'h0, pv & len < LEN_64}, pv & len > LEN_9215,
      g & dst == DEST_UNICAST, g & dst == DEST_MULTICAST,
      g & dst == DEST_BROADCAST, o & !fb, o, o & fb,
      {3'h0, pv & !fb & len < mn}, {3'h0, pv & fb & len < mn}, g & vl,
      pv & lf & !fb, pv & pz & !fb, pv & pp & !fb};
  endfunction : ex

  task chk(input logic [75:0] g, input logic [75:0] x, input string what);
    tests_run++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("FAIL at %0t: %s got %h want %h", $time, what, g, x);
    end
  endtask : chk

  // one cycle: check last cycle's outputs, apply new inputs; z keeps quiet
  task step(input bit z, input logic [13:0] l, input logic [8:0] f);
    @(posedge clk);
    {pv, fb, fe, dst, vl, lf, pz, pp} <= z ? 9'h0 : f;
    len <= l;
    {sig, mkv, mkp, cb, bv, bi} <= z ? 26'h0 : 26'($urandom);
    #1;
    chk(got[75:72], e[75:72], "status");
    chk(got[71:55], e[71:55], "marker");
    chk(got[54:35], e[54:35], "counts");
    chk(got[34:18], e[34:18], "sizes");
    chk(got[17:8], e[17:8], "classes");
    chk(got[7:0], e[7:0], "kinds");
    if (mkv) lp = mkp;
    e = ex();
    sp += 32'(e[54:51]);
    sb += 32'(e[62:55]);
    sg += 32'(e[49:36]);
  endtask : step

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] xr);
    bit ad, wd;
    ad = 0;
    wd = 0;
    step(1, 14'h0, 9'h0);
    @(posedge clk);
    {awaddr, wdata, wstrb} <= {a, d, s};
    {awvalid, wvalid, bready} <= 3'h7;
    while (!(ad && wd))
    begin
      @(posedge clk);
      if (awvalid && awready)
      begin
        ad = 1;
        awvalid <= 0;
      end
      if (wvalid && wready)
      begin
        wd = 1;
        wvalid <= 0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 0;
    chk(76'(bresp), 76'(xr), "bresp");
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] xd, input logic [1:0] xr);
    step(1, 14'h0, 9'h0);
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 0;
    chk(76'(rdata), 76'(xd), "rdata");
    chk(76'(rresp), 76'(xr), "rresp");
  endtask : rd

  task corners();
    foreach (cl[i])
    begin
      step(0, cl[i], {3'b100, 2'(i % 3), 4'hf});
      step(0, cl[i], {3'b110, 2'(i % 3), 4'hf});
      step(0, cl[i], {3'b101, 2'(i % 3), 4'ha});
    end
  endtask : corners

  task rnd(input int n);
    repeat (n) step(0, 14'($urandom_range(0, 2100)), 9'($urandom));
    repeat (n) step(0, 14'($urandom), 9'($urandom));
  endtask : rnd

  task results();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  // watchdog sized well past the roughly 1500 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end

  initial
  begin
    void'($urandom(82));
    repeat (6) @(posedge clk);
    rst <= 0;
    rd(CTRL_OFFS, 32'h0, RESP_OKAY);
    rd(MAX_LEN_OFFS, 32'(MAX_LEN_RST), RESP_OKAY);
    rd(MIN_LEN_OFFS, 32'(MIN_LEN_RST), RESP_OKAY);
    rd(8'h10, 32'h0, RESP_DECERR);
    wr(8'h10, 32'hffff_ffff, 4'hf, RESP_DECERR);
    wr(STATUS_OFFS, 32'hffff_ffff, 4'hf, RESP_OKAY);
    rd(STATUS_OFFS, 32'(lp), RESP_OKAY);
    $display("test registers done");
    corners();
    rnd(300);
    $display("test default limits done");
    wr(CTRL_OFFS, 32'h1, 4'hf, RESP_OKAY);
    tp = 1;
    rnd(150);
    rd(STATUS_OFFS, {23'h0, tp, lp}, RESP_OKAY);
    wr(CTRL_OFFS, 32'h0, 4'hf, RESP_OKAY);
    tp = 0;
    $display("test pattern done");
    wr(MAX_LEN_OFFS, 32'd2000, 4'hf, RESP_OKAY);
    mx = 14'd2000;
    // only byte lane 0 lands, so 0x0040 becomes 0x0034
    wr(MIN_LEN_OFFS, 32'hffff_ff34, 4'h1, RESP_OKAY);
    mn = 14'h0034;
    rd(MIN_LEN_OFFS, 32'h34, RESP_OKAY);
    corners();
    rnd(150);
    step(1, 14'h0, 9'h0);
    step(1, 14'h0, 9'h0);
    chk({ap, ab}, {sp, sb}, "totals");
    chk(76'(ag), 76'(sg), "good totals");
    $display("test new limits done");
    results();
  end
endmodule : tb
